// [design/mpur_pkg.sv]
package mpur_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses on the apb bus)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_PROGRAM_COUNTER = 8'h00;
   localparam logic [7:0] OFS_STACK_POINTER = 8'h04;
   localparam logic [7:0] OFS_INDEX_POINTER = 8'h08;
   localparam logic [7:0] OFS_ACCUMULATOR_PAIR = 8'h0C;
   localparam logic [7:0] OFS_CONDITION_FLAGS = 8'h10;
   localparam logic [7:0] OFS_ALU_COMMAND = 8'h14;
   localparam logic [7:0] OFS_MEM_COMMAND = 8'h18;
   localparam logic [7:0] OFS_MEM_DATA = 8'h1C;
   localparam logic [7:0] OFS_BUS_STATUS = 8'h20;

   // ------------------------------------------------------------
   // condition flag layout and reset values
   // ------------------------------------------------------------
   localparam int CCR_CARRY = 0;
   localparam int CCR_OVERFLOW = 1;
   localparam int CCR_ZERO = 2;
   localparam int CCR_NEGATIVE = 3;
   localparam int CCR_IMASK = 4;
   localparam int CCR_HALF = 5;
   localparam logic [7:0] CCR_ONES_MASK = 8'hC0;
   localparam logic [7:0] CCR_RESET = 8'hD0;
   localparam logic [15:0] PC_RESET = 16'hFFFE;
   localparam logic [15:0] SP_RESET = 16'h0000;

   // ------------------------------------------------------------
   // command field positions
   // ------------------------------------------------------------
   localparam int ALU_OPERAND_LSB = 0;
   localparam int ALU_OP_LSB = 8;
   localparam int ALU_SEL_B = 12;
   localparam int MEM_ADDR_LSB = 0;
   localparam int MEM_WRITE_BIT = 16;
   localparam int MEM_FETCH_BIT = 17;
   localparam int MEM_INDEXED_BIT = 18;

   // ------------------------------------------------------------
   // memory map and timing
   // ------------------------------------------------------------
   localparam int RAM_BYTES = 128;
   localparam int RAM_RETAIN_BYTES = 32;
   localparam int OSC_PER_PHASE = 4;
   localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_PHASE - 1);

   typedef enum logic [2:0] {
      ALU_LOAD = 3'h0,
      ALU_ADD = 3'h1,
      ALU_SUB = 3'h2,
      ALU_AND = 3'h3,
      ALU_OR = 3'h4,
      ALU_XOR = 3'h5,
      ALU_INC = 3'h6,
      ALU_DEC = 3'h7
   } mpur_alu_op_type;

   typedef enum logic [3:0] {
      BUS_IDLE = 4'h1,
      BUS_ALIGN = 4'h2,
      BUS_CYCLE = 4'h4,
      BUS_STRETCH = 4'h8
   } mpur_bus_state_type;

   typedef struct packed {
      logic [7:0] result;
      logic half;
      logic negative;
      logic zero;
      logic overflow;
      logic carry;
   } mpur_alu_out_type;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic data_oe;
      logic read_not_write;
      logic valid_addr;
      logic phase_e;
   } mpur_bus_pins_type;
endpackage

// [design/mpur_ram.sv]
`timescale 1ns/100ps
module mpur_ram
   import mpur_pkg::*;
#(
   parameter int BYTES = RAM_BYTES,
   parameter int RETAIN = RAM_RETAIN_BYTES
) (
   input wire logic i_clk, // core clock
   input wire logic i_ce, // clock enable
   input wire logic i_power_down, // standby supply only
   input wire logic i_write, // write strobe
   input wire logic [6:0] i_index, // byte index
   input wire logic [7:0] i_wdata, // write data
   output logic [7:0] o_rdata // read data
);
   typedef struct packed {
      logic [BYTES-1:0][7:0] mem;
   } mpur_ram_state_type;

   mpur_ram_state_type r;
   mpur_ram_state_type next_r;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // no reset: the low bytes must survive a reset
   always_comb begin
      next_r = r;
      if (i_write) begin
         next_r.mem[i_index] = i_wdata;
      end
      for (int i = RETAIN; i < BYTES; i++) begin
         if (i_power_down) begin
            next_r.mem[i] = 8'h00; // upper bytes lose content
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         r <= next_r;
      end
   end

   assign o_rdata = r.mem[i_index];
endmodule

// [design/mpur_top.sv]
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// - 128 bytes of internal RAM decode fully at addresses 0x0000 to 0x007F.
// - lowest 32 RAM bytes survive low power; upper bytes may be lost.
// - RAM-select input governs retention of low bytes across supply changes.
// - 16-bit program counter holds the address of the current instruction.
// - 16-bit stack pointer marks next free stack slot, placed anywhere.
// - 16-bit index register holds data or an address for indexed access.
// - two independent 8-bit accumulators feed and receive the ALU.
// - ALU updates N, Z, V, H; carry from bit 7, half-carry from bit 3.
// - interrupt mask sits at bit 4; bits 6 and 7 always read one.
// - bus phase clock made on chip from an oscillator at four times rate.
// - internal RAM access drives the data bus out and ignores external data.
module mpur_top
   import mpur_pkg::*;
#(
   parameter bit FAST_GRADE = 1'b0, // faster speed grade
   parameter int FETCH_STRETCH = 1 // extra phases for base-grade ram fetch
) (
   input wire logic I_CLK, // oscillator clock, four times bus rate
   input wire logic I_RESET, // synchronous reset, active high
   input wire logic I_CE, // clock enable
   input wire logic I_PSEL, // apb select
   input wire logic I_PENABLE, // apb enable
   input wire logic I_PWRITE, // apb direction
   input wire logic [7:0] I_PADDR, // apb byte address
   input wire logic [31:0] I_PWDATA, // apb write data
   output logic [31:0] O_PRDATA, // apb read data
   output logic O_PREADY, // apb ready
   output logic O_PSLVERR, // apb error
   input wire logic I_ONCHIP_RAM_SELECT, // internal ram enable pin
   input wire logic I_POWER_DOWN, // low power, standby supply only
   input wire logic [7:0] I_DATA, // data bus input
   output logic [7:0] O_DATA, // data bus output
   output logic O_DATA_OE, // data bus drive enable
   output logic [15:0] O_ADDR, // address bus
   output logic O_READ_NOT_WRITE, // high for read
   output logic O_VALID_ADDR, // valid memory address
   output logic O_PHASE_E // bus phase clock
);
   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] sp;
      logic [15:0] ix;
      logic [7:0] acc_a;
      logic [7:0] acc_b;
      logic [7:0] ccr;
      logic [15:0] mem_addr;
      logic [7:0] mem_wdata;
      logic [7:0] mem_rdata;
      logic mem_write;
      logic mem_fetch;
      logic mem_internal;
      logic fetch_fault;
      logic [1:0] phase;
      logic [3:0] stretch;
      mpur_bus_state_type state;
      logic sel_meta;
      logic sel_sync;
      logic pd_meta;
      logic pd_sync;
      logic [7:0] din_meta;
      logic [7:0] din_sync;
      mpur_bus_pins_type pins;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } mpur_state_type;

   mpur_state_type r;
   mpur_state_type next_r;
   logic [7:0] ram_rdata;
   logic ram_write;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // alu with flag generation
   function automatic mpur_alu_out_type alu(input mpur_alu_op_type op,
                                            input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic c_in);
      mpur_alu_out_type o;
      logic [8:0] sum;
      logic [4:0] low;
      o = '0;
      sum = 9'h000;
      low = 5'h00;
      o.carry = c_in;
      case (op)
         ALU_ADD: begin
            sum = {1'b0, a} + {1'b0, b};
            low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
            o.half = low[4]; // carry out of bit 3
            o.carry = sum[8]; // carry out of bit 7
            o.overflow = (a[7] == b[7]) && (sum[7] != a[7]);
         end
         ALU_SUB: begin
            sum = {1'b0, a} - {1'b0, b};
            o.carry = sum[8];
            o.overflow = (a[7] != b[7]) && (sum[7] != a[7]);
         end
         ALU_INC: begin
            sum = {1'b0, a} + 9'h001;
            o.overflow = (a == 8'h7F);
         end
         ALU_DEC: begin
            sum = {1'b0, a} - 9'h001;
            o.overflow = (a == 8'h80);
         end
         ALU_AND: sum = {1'b0, a & b};
         ALU_OR: sum = {1'b0, a | b};
         ALU_XOR: sum = {1'b0, a ^ b};
         ALU_LOAD: sum = {1'b0, b};
         default: sum = {1'b0, a};
      endcase
      o.result = sum[7:0];
      o.negative = sum[7];
      o.zero = (sum[7:0] == 8'h00);
      return o;
   endfunction

   // apb access phase that completes at this edge
   function automatic logic apb_done(input logic sel, input logic en, input logic rdy);
      return sel && en && rdy;
   endfunction

   // internal ram decode: low 128 bytes and select high
   function automatic logic ram_hit(input logic [15:0] addr, input logic sel);
      return (addr < 16'(RAM_BYTES)) && sel;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      mpur_alu_out_type a_out;
      logic [15:0] eff;
      logic wr;
      logic rd;
      next_r = r;
      a_out = '0;
      eff = 16'h0000;
      wr = apb_done(I_PSEL, I_PENABLE, r.pready) && I_PWRITE;
      rd = I_PSEL && I_PENABLE && !r.pready;

      // pin synchronisers; first stage feeds only the second
      next_r.sel_meta = I_ONCHIP_RAM_SELECT;
      next_r.sel_sync = r.sel_meta;
      next_r.pd_meta = I_POWER_DOWN;
      next_r.pd_sync = r.pd_meta;
      next_r.din_meta = I_DATA;
      next_r.din_sync = r.din_meta;

      // phase clock divided from the oscillator
      next_r.phase = r.phase + 2'h1;
      next_r.pins.phase_e = next_r.phase[1];

      // apb answer one cycle into the access phase
      next_r.pready = rd;
      next_r.pslverr = 1'b0;
      if (rd) begin
         next_r.prdata = 32'h0000_0000;
         case (I_PADDR)
            OFS_PROGRAM_COUNTER: next_r.prdata[15:0] = r.pc;
            OFS_STACK_POINTER: next_r.prdata[15:0] = r.sp;
            OFS_INDEX_POINTER: next_r.prdata[15:0] = r.ix;
            OFS_ACCUMULATOR_PAIR: next_r.prdata[15:0] = {r.acc_b, r.acc_a};
            OFS_CONDITION_FLAGS: next_r.prdata[7:0] = r.ccr | CCR_ONES_MASK;
            OFS_ALU_COMMAND: next_r.prdata = 32'h0000_0000;
            OFS_MEM_COMMAND: begin
               next_r.prdata[15:0] = r.mem_addr;
               next_r.prdata[MEM_WRITE_BIT] = r.mem_write;
               next_r.prdata[MEM_FETCH_BIT] = r.mem_fetch;
               // a command while busy is refused together with the answer
               if (I_PWRITE && (r.state != BUS_IDLE)) begin
                  next_r.pslverr = 1'b1;
               end
            end
            OFS_MEM_DATA: next_r.prdata[7:0] = r.mem_rdata;
            OFS_BUS_STATUS: begin
               next_r.prdata[0] = (r.state != BUS_IDLE);
               next_r.prdata[1] = r.mem_internal;
               next_r.prdata[2] = r.fetch_fault;
               next_r.prdata[3] = r.sel_sync;
               next_r.prdata[4] = r.pd_sync;
            end
            default: next_r.pslverr = 1'b1; // unmapped
         endcase
      end

      // register writes take effect at the completing edge
      if (wr) begin
         case (I_PADDR)
            OFS_PROGRAM_COUNTER: next_r.pc = I_PWDATA[15:0];
            OFS_STACK_POINTER: next_r.sp = I_PWDATA[15:0]; // any location
            OFS_INDEX_POINTER: next_r.ix = I_PWDATA[15:0]; // data or address
            OFS_ACCUMULATOR_PAIR: begin
               next_r.acc_a = I_PWDATA[7:0];
               next_r.acc_b = I_PWDATA[15:8];
            end
            OFS_CONDITION_FLAGS: next_r.ccr = I_PWDATA[7:0] | CCR_ONES_MASK;
            OFS_ALU_COMMAND: begin
               a_out = alu(mpur_alu_op_type'(I_PWDATA[ALU_OP_LSB +: 3]),
                           I_PWDATA[ALU_SEL_B] ? r.acc_b : r.acc_a,
                           I_PWDATA[ALU_OPERAND_LSB +: 8], r.ccr[CCR_CARRY]);
               // result lands in the chosen accumulator
               if (I_PWDATA[ALU_SEL_B]) begin
                  next_r.acc_b = a_out.result;
               end else begin
                  next_r.acc_a = a_out.result;
               end
               next_r.ccr[CCR_NEGATIVE] = a_out.negative;
               next_r.ccr[CCR_ZERO] = a_out.zero;
               next_r.ccr[CCR_OVERFLOW] = a_out.overflow;
               next_r.ccr[CCR_CARRY] = a_out.carry;
               next_r.ccr[CCR_HALF] = a_out.half;
            end
            OFS_MEM_DATA: next_r.mem_wdata = I_PWDATA[7:0];
            OFS_MEM_COMMAND: begin
               // refused in the access cycle before, so it is dropped here
               if (!r.pslverr) begin
                  eff = I_PWDATA[MEM_ADDR_LSB +: 16];
                  if (I_PWDATA[MEM_INDEXED_BIT]) begin
                     eff = r.ix + {8'h00, eff[7:0]}; // indexed mode
                  end
                  next_r.mem_addr = eff;
                  next_r.mem_write = I_PWDATA[MEM_WRITE_BIT];
                  next_r.mem_fetch = I_PWDATA[MEM_FETCH_BIT];
                  next_r.mem_internal = ram_hit(eff, r.sel_sync);
                  next_r.fetch_fault = 1'b0;
                  // fast grades refuse to run code from internal ram
                  if (FAST_GRADE && I_PWDATA[MEM_FETCH_BIT] && next_r.mem_internal) begin
                     next_r.fetch_fault = 1'b1;
                  end else begin
                     next_r.state = BUS_ALIGN;
                  end
               end
            end
            // unmapped or read-only status: any error came with the ready pulse and must not outlast it
            default: next_r.pslverr = 1'b0;
         endcase
      end
      if (apb_done(I_PSEL, I_PENABLE, r.pready) && !I_PWRITE) begin
         next_r.pslverr = 1'b0;
      end

      // bus cycle sequencer, one phase clock period per access, plus FETCH_STRETCH periods for an internal ram fetch
      case (r.state)
         BUS_IDLE: begin
            next_r.pins.valid_addr = 1'b0;
            next_r.pins.data_oe = 1'b0;
            next_r.pins.read_not_write = 1'b1;
         end
         BUS_ALIGN: begin
            // start on a phase boundary so the E period is whole
            if (r.phase == PHASE_LAST) begin
               next_r.state = BUS_CYCLE;
               next_r.pins.addr = r.mem_addr;
               next_r.pins.read_not_write = !r.mem_write;
               next_r.pins.valid_addr = 1'b1;
               next_r.stretch = (r.mem_fetch && r.mem_internal) ? 4'(FETCH_STRETCH) : 4'h0;
               // internal access drives the bus even on a read
               next_r.pins.data_oe = r.mem_write || r.mem_internal;
               next_r.pins.data = (r.mem_internal && !r.mem_write) ? ram_rdata : r.mem_wdata;
            end
         end
         BUS_CYCLE, BUS_STRETCH: begin
            if (r.phase == PHASE_LAST) begin
               if (r.stretch != 4'h0) begin
                  // slower address-valid for base-grade ram fetch
                  next_r.stretch = r.stretch - 4'h1;
                  next_r.state = BUS_STRETCH;
               end else begin
                  next_r.state = BUS_IDLE;
                  next_r.pins.valid_addr = 1'b0;
                  next_r.pins.data_oe = 1'b0;
                  next_r.pins.read_not_write = 1'b1;
                  if (!r.mem_write) begin
                     // external data ignored on internal hits
                     next_r.mem_rdata = r.mem_internal ? ram_rdata : r.din_sync;
                  end
                  if (r.mem_fetch) begin
                     next_r.pc = r.mem_addr; // current instruction address
                  end
               end
            end
         end
         default: next_r.state = BUS_IDLE;
      endcase

      // unused bits 6 and 7 survive every path
      next_r.ccr = next_r.ccr | CCR_ONES_MASK;
   end

   // ram write at the end of an internal write cycle; select low blocks it
   assign ram_write = (r.state == BUS_CYCLE) && (r.phase == PHASE_LAST) && (r.stretch == 4'h0)
                      && r.mem_internal && r.mem_write && r.sel_sync;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         r <= '0;
         r.pc <= PC_RESET;
         r.sp <= SP_RESET;
         r.ccr <= CCR_RESET; // mask set out of reset
         r.state <= BUS_IDLE;
         r.pins.read_not_write <= 1'b1;
         r.pins.addr <= PC_RESET;
      end else if (I_CE) begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // internal ram
   // ------------------------------------------------------------
   mpur_ram #(
      .BYTES(RAM_BYTES),
      .RETAIN(RAM_RETAIN_BYTES)
   ) mpur_ram_i (
      .i_clk(I_CLK),
      .i_ce(I_CE),
      .i_power_down(r.pd_sync),
      .i_write(ram_write),
      .i_index(r.mem_addr[6:0]),
      .i_wdata(r.mem_wdata),
      .o_rdata(ram_rdata)
   );

   // outputs straight from flip-flops
   assign O_PRDATA = r.prdata;
   assign O_PREADY = r.pready;
   assign O_PSLVERR = r.pslverr;
   assign O_DATA = r.pins.data;
   assign O_DATA_OE = r.pins.data_oe;
   assign O_ADDR = r.pins.addr;
   assign O_READ_NOT_WRITE = r.pins.read_not_write;
   assign O_VALID_ADDR = r.pins.valid_addr;
   assign O_PHASE_E = r.pins.phase_e;
endmodule

// [tb/mpur_ext_mem.sv]
`timescale 1ns/100ps
module mpur_ext_mem (
   input wire logic i_clk, // bus clock
   input wire logic [15:0] i_addr, // address bus
   input wire logic i_valid_addr, // valid address
   input wire logic i_read_not_write, // high for read
   input wire logic i_ram_select, // internal ram enable pin
   input wire logic [7:0] i_data, // resolved data bus
   output logic [7:0] o_data // data driven by this memory
);
   logic [7:0] mem [0:255];
   logic [7:0] last;
   logic mine;
   // only the low address byte is decoded, so the map mirrors every 256 bytes
   initial begin
      for (int k = 0; k < 256; k++) begin
         mem[k] = 8'(k) ^ 8'h5A;
      end
      last = 8'h00;
      o_data = 8'h00;
   end
   // stay off the bus whenever the internal ram owns the address
   assign mine = i_valid_addr && !(i_ram_select && i_addr < 16'h0080);
   // a released line shows a changing pattern, never the last value
   always @(posedge i_clk) begin
      if (mine && i_read_not_write) begin
         o_data <= mem[i_addr[7:0]];
         last <= mem[i_addr[7:0]];
      end else begin
         o_data <= ~last;
         last <= ~last;
      end
      if (mine && !i_read_not_write) begin
         mem[i_addr[7:0]] <= i_data;
      end
   end
endmodule

// [tb/mpur_top_checker.sv]
`timescale 1ns/100ps
module mpur_top_checker
   import mpur_pkg::*;
(
   input wire logic I_CLK, // clock
   input wire logic I_RESET, // reset
   input wire logic I_PSEL, // apb select
   input wire logic I_PENABLE, // apb enable
   input wire logic I_PWRITE, // apb direction
   input wire logic [7:0] I_PADDR, // apb address
   input wire logic [31:0] O_PRDATA, // apb read data
   input wire logic O_PREADY, // apb ready
   input wire logic O_PSLVERR, // apb error
   input wire logic O_DATA_OE, // data drive enable
   input wire logic [15:0] O_ADDR, // address bus
   input wire logic O_READ_NOT_WRITE, // high for read
   input wire logic O_VALID_ADDR, // valid address
   input wire logic O_PHASE_E // phase clock
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RESET);
   // ---------------------------------------------
   // register bus
   // ---------------------------------------------
   pready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready held longer than one cycle");
   pready_wait_a: assert property (
      I_PSEL && I_PENABLE && !O_PREADY && !$past(I_PENABLE) |=> O_PREADY)
      else $error("ready not after one wait state");
   slverr_ready_a: assert property (O_PSLVERR |-> O_PREADY)
      else $error("error without ready");
   unmapped_err_a: assert property (O_PREADY && I_PADDR > OFS_BUS_STATUS |-> O_PSLVERR)
      else $error("unmapped offset not refused");
   ccr_ones_a: assert property (
      O_PREADY && !I_PWRITE && I_PADDR == OFS_CONDITION_FLAGS |-> O_PRDATA[7:6] == 2'b11)
      else $error("flag bits 7 and 6 not one");
   // ---------------------------------------------
   // memory bus
   // ---------------------------------------------
   phase_period_a: assert property (
      $rose(O_PHASE_E) |=> O_PHASE_E ##1 !O_PHASE_E ##1 !O_PHASE_E ##1 O_PHASE_E)
      else $error("phase clock not a quarter of the clock");
   cycle_len_a: assert property (
      $rose(O_VALID_ADDR) |-> O_VALID_ADDR [*4] ##[1:5] !O_VALID_ADDR)
      else $error("bus cycle length wrong");
   internal_drive_a: assert property (
      O_VALID_ADDR && O_READ_NOT_WRITE && O_DATA_OE |-> O_ADDR[15:7] == 9'h000)
      else $error("read drives data bus outside internal ram");
   addr_stable_a: assert property (
      O_VALID_ADDR && $past(O_VALID_ADDR) |-> $stable(O_ADDR) && $stable(O_DATA_OE))
      else $error("address moved within a bus cycle");
endmodule

bind mpur_top mpur_top_checker mpur_top_checker_i (.I_CLK(I_CLK), .I_RESET(I_RESET),
   .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
   .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_DATA_OE(O_DATA_OE),
   .O_ADDR(O_ADDR), .O_READ_NOT_WRITE(O_READ_NOT_WRITE), .O_VALID_ADDR(O_VALID_ADDR),
   .O_PHASE_E(O_PHASE_E));

// [tb/mpur_top_tb.sv]
`timescale 1ns/100ps
module mpur_top_tb;
   import mpur_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic ram_sel = 1'b1, pdown = 1'b0, pready, pslverr, doe, rnw, vma, phase, er;
   logic [7:0] paddr = 8'h00, dout, ext_q, bus;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] addr;
   int bad_count = 0, num_checks = 0, cycles = 0;

   always #25 clk = ~clk;
   // the data pin carries the device when it drives, else the memory
   assign bus = doe ? dout : ext_q;
   // hang guard, well above the length of the run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         bad_count++;
         end_of_test();
      end
   end

   mpur_top mpur_top_i (.I_CLK(clk), .I_RESET(rst), .I_CE(1'b1), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_ONCHIP_RAM_SELECT(ram_sel), .I_POWER_DOWN(pdown), .I_DATA(bus), .O_DATA(dout),
      .O_DATA_OE(doe), .O_ADDR(addr), .O_READ_NOT_WRITE(rnw), .O_VALID_ADDR(vma),
      .O_PHASE_E(phase));
   mpur_ext_mem mpur_ext_mem_i (.i_clk(clk), .i_addr(addr), .i_valid_addr(vma),
      .i_read_not_write(rnw), .i_ram_select(ram_sel), .i_data(bus), .o_data(ext_q));

   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask
   // request held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         $display("Error pready expected 1 seen %b", pready);
         bad_count++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      check(what, exp, rd);
   endtask
   // status is polled, so rd holds it on return
   task automatic mem_op(input logic [18:0] cmd, input logic [7:0] wd);
      int n;
      n = 0;
      apb(1'b1, OFS_MEM_DATA, {24'h0, wd});
      apb(1'b1, OFS_MEM_COMMAND, {13'h0, cmd});
      do begin
         apb(1'b0, OFS_BUS_STATUS, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 40);
      if (rd[0] !== 1'b0) begin
         $display("Error busy expected 0 seen %b", rd[0]);
         bad_count++;
      end
   endtask
   task automatic ram_rd(input logic [15:0] a, input logic [31:0] exp, input string what);
      mem_op({3'b000, a}, 8'h00);
      rd_chk(OFS_MEM_DATA, exp, what);
   endtask

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_reset();
      check("bus idle", 32'h0002FFFE, {13'h0, doe, rnw, vma, addr});
      rd_chk(OFS_PROGRAM_COUNTER, 32'h0000FFFE, "pc reset");
      rd_chk(OFS_STACK_POINTER, 32'h0, "sp reset");
      rd_chk(OFS_INDEX_POINTER, 32'h0, "ix reset");
      rd_chk(OFS_ACCUMULATOR_PAIR, 32'h0, "acc reset");
      rd_chk(OFS_CONDITION_FLAGS, 32'h000000D0, "ccr reset");
   endtask
   task automatic t_regs();
      apb(1'b1, OFS_STACK_POINTER, 32'h0000ABCD);
      rd_chk(OFS_STACK_POINTER, 32'h0000ABCD, "sp");
      apb(1'b1, OFS_INDEX_POINTER, 32'h0000BEEF);
      rd_chk(OFS_INDEX_POINTER, 32'h0000BEEF, "ix");
      apb(1'b1, OFS_PROGRAM_COUNTER, 32'h00004321);
      rd_chk(OFS_PROGRAM_COUNTER, 32'h00004321, "pc");
   endtask
   // 0x7F + 1 overflows and carries out of bit 3; 0xFF + 1 wraps to zero
   task automatic t_alu();
      apb(1'b1, OFS_ALU_COMMAND, 32'h0000007F);
      apb(1'b1, OFS_ALU_COMMAND, 32'h00000101);
      rd_chk(OFS_CONDITION_FLAGS, 32'h000000FA, "ccr add a");
      apb(1'b1, OFS_ALU_COMMAND, 32'h000010FF);
      apb(1'b1, OFS_ALU_COMMAND, 32'h00001101);
      rd_chk(OFS_CONDITION_FLAGS, 32'h000000F5, "ccr add b");
      rd_chk(OFS_ACCUMULATOR_PAIR, 32'h00000080, "acc pair");
      apb(1'b1, OFS_CONDITION_FLAGS, 32'h0);
      rd_chk(OFS_CONDITION_FLAGS, 32'h000000C0, "ccr ones");
   endtask
   task automatic t_ram();
      mem_op({3'b001, 16'h0005}, 8'hA5);
      check("hit low", 1'b1, rd[1]);
      mem_op({3'b001, 16'h007F}, 8'h3C);
      mem_op({3'b001, 16'h0085}, 8'hC3);
      check("hit ext", 1'b0, rd[1]);
      ram_rd(16'h0005, 32'h000000A5, "ram 05");
      ram_rd(16'h007F, 32'h0000003C, "ram 7f");
      ram_rd(16'h0085, 32'h000000C3, "ext 85");
      ram_sel <= 1'b0;
      repeat (4) @(posedge clk);
      ram_rd(16'h0005, 32'h0000005F, "no ram 05");
      ram_sel <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // the system drops the select line around the supply change
   task automatic t_power();
      mem_op({3'b001, 16'h0010}, 8'h11);
      mem_op({3'b001, 16'h0040}, 8'h44);
      ram_sel <= 1'b0;
      pdown <= 1'b1;
      repeat (8) @(posedge clk);
      pdown <= 1'b0;
      ram_sel <= 1'b1;
      repeat (4) @(posedge clk);
      ram_rd(16'h0010, 32'h00000011, "kept 10");
      ram_rd(16'h0040, 32'h00000000, "lost 40");
   endtask
   task automatic t_fetch();
      mem_op({3'b010, 16'h0008}, 8'h00);
      rd_chk(OFS_PROGRAM_COUNTER, 32'h00000008, "pc int");
      mem_op({3'b010, 16'h1200}, 8'h00);
      rd_chk(OFS_PROGRAM_COUNTER, 32'h00001200, "pc ext");
      apb(1'b1, OFS_INDEX_POINTER, 32'h00001000);
      mem_op({3'b100, 16'h0034}, 8'h00);
      rd_chk(OFS_MEM_DATA, 32'h0000006E, "indexed");
   endtask
   task automatic t_err();
      apb(1'b0, 8'h24, 32'h0);
      check("err read", 1'b1, er);
      apb(1'b1, 8'h28, 32'h0);
      check("err write", 1'b1, er);
      // a second command while the first runs is refused and dropped
      apb(1'b1, OFS_MEM_COMMAND, 32'h0000_1200);
      apb(1'b1, OFS_MEM_COMMAND, 32'h0002_1300);
      check("err busy", 1'b1, er);
      repeat (12) @(posedge clk);
      rd_chk(OFS_PROGRAM_COUNTER, 32'h00001200, "pc kept");
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_alu();
      t_ram();
      t_power();
      t_fetch();
      t_err();
      end_of_test();
   end
endmodule
